/* File: asrx_consts.vh */
/*
 * Constants of the asynchronous serial receiver: register offsets,
 * field positions, reset values and oversampling figures.
 * Assumes inclusion by its bare name from the receiver design file.
 */
`ifndef ASRX_CONSTS_VH
`define ASRX_CONSTS_VH

// Register offsets
`define ASRX_REG_CTRL 4'h0
`define ASRX_REG_STAT 4'h1
`define ASRX_REG_DATA 4'h2
`define ASRX_REG_BAUD 4'h3
`define ASRX_REG_IRQ 4'h4
`define ASRX_REG_MASK 4'h5

// Control fields (receive_status_control plus mode bits)
`define ASRX_CTL_RXEN 0
`define ASRX_CTL_SYNC 1
`define ASRX_CTL_PEN 2
`define ASRX_CTL_NINE 3
`define ASRX_CTL_ADDR 4
`define ASRX_CTL_W 5
`define ASRX_CTRL_RST 5'h00

// Status fields
`define ASRX_ST_RXF 0
`define ASRX_ST_OERR 1
`define ASRX_ST_FERR 2
`define ASRX_ST_BIT8 3

// Interrupt event fields
`define ASRX_EV_CHAR 0
`define ASRX_EV_OERR 1
`define ASRX_EV_FERR 2
`define ASRX_EV_W 3

// Baud tick divisor reset: ticks at 16 times the bit rate
`define ASRX_BAUD_RST 16'h0081

// Oversampling: last tick index of a bit (16 ticks per bit) and the three centre samples
`define ASRX_OVS 4'hF
`define ASRX_SMP_A 4'h7
`define ASRX_SMP_B 4'h8
`define ASRX_SMP_C 4'h9

`endif

/* File: asrx_receiver.v */
/*
 * Asynchronous serial receiver: 16x oversampling data recovery, shift
 * register, two-entry character FIFO, error detection, interrupt logic
 * and pin-direction overrides of the serial port.
 * Assumes one 20 MHz clock, a plain register port and an outside
 * transmitter feeding tx_serial_data.
 */
// Functional notes
// RQ1: Line sampled at sixteen ticks per bit; shift register moves once per bit.
// RQ2: Characters are eight or nine data bits, chosen by software.
// RQ3: A finished character goes straight from shift register into FIFO.
// RQ4: FIFO holds two characters while a third shifts in.
// RQ5: Shift register and FIFO reachable only through the receive data register.
// RQ6: Reception runs only with receive enable 1, mode 0, port enable 1.
// RQ7: Receive enable bit switches receiver circuitry on and off.
// RQ8: Port enable switches module on and makes receive pin an input.
// RQ9: Port enable forces transmit pin to drive, whatever its direction bit.
// RQ10: Port enable disconnects the port latch from the transmit pin.
// RQ11: Software clears analog select of receive pin before serial use.
// RQ12: Overrun of the input buffer is detected and reported.
// RQ13: Framing error is detected per character and reported.
// RQ14: Nine-bit mode offers address detection using the ninth bit.
// RQ15: Start on falling edge; recheck at half bit, abandon quietly if high.
// RQ16: Bits taken by majority at centre; low stop bit flags framing error.
// RQ17: After stop, character enters FIFO; data read pops the oldest.
// RQ18: After overrun no characters accepted until overrun cleared.
// RQ19: Receive flag read-only, set while enabled and unread data remain.
`timescale 1ns/1ps
`include "asrx_consts.vh"

module asrx_receiver #(
    parameter AW = 1,
    parameter DIV_W = 16
)(
    input wire clk,
    input wire rst,
    input wire [3:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rd_data,
    output wire irq,
    input wire receive_pin_in,
    output wire receive_pin_oe_n,
    output wire receive_pin_out,
    input wire rx_port_latch,
    input wire rx_dir_bit,
    output wire transmit_pin_oe_n,
    output wire transmit_pin_out,
    input wire tx_serial_data,
    input wire tx_port_latch,
    input wire tx_dir_bit
);

    localparam DEPTH = 1 << AW;
    localparam S_IDLE = 2'b00;
    localparam S_START = 2'b01;
    localparam S_DATA = 2'b10;
    localparam S_STOP = 2'b11;

    reg [`ASRX_CTL_W-1:0] ctrl;
    reg [DIV_W-1:0] baud_div;
    reg [`ASRX_EV_W-1:0] irq_st;
    reg [`ASRX_EV_W-1:0] irq_mask;
    reg overrun;
    reg rx_s1;
    reg rx_s2;
    reg rx_prev;
    reg [DIV_W-1:0] tick_cnt;
    reg [3:0] sub;
    reg [1:0] state;
    reg [3:0] bit_cnt;
    reg [8:0] receive_shift_register;
    reg [1:0] votes;
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0] count;
    reg [10:0] entry [0:DEPTH-1];
    reg push;
    reg [10:0] push_word;
    reg ev_oerr;

    wire rx_enable = ctrl[`ASRX_CTL_RXEN];
    wire port_enable = ctrl[`ASRX_CTL_PEN];
    wire nine = ctrl[`ASRX_CTL_NINE];
    wire active = rx_enable & ~ctrl[`ASRX_CTL_SYNC] & port_enable; // RQ6 RQ7
    wire tick = (tick_cnt == {DIV_W{1'b0}});
    wire maj = (votes[1] & votes[0]) | (votes[1] & rx_s2) | (votes[0] & rx_s2);
    wire centre = tick & (sub == `ASRX_SMP_C);
    wire [3:0] last_bit = nine ? 4'h8 : 4'h7;
    wire full = (count == DEPTH[AW:0]);
    wire empty = (count == {(AW+1){1'b0}});
    wire pop = rd_en & (addr == `ASRX_REG_DATA) & ~empty; // RQ17
    wire rd_irq = rd_en & (addr == `ASRX_REG_IRQ);
    wire rx_flag = rx_enable & ~empty; // RQ19
    wire [10:0] top = entry[rptr];
    wire [`ASRX_EV_W-1:0] events;

    ////////////////////////////////////////////////////////////////////
    // Pin direction overrides
    ////////////////////////////////////////////////////////////////////

    // Receive pin becomes an input while the port is enabled
    assign receive_pin_oe_n = port_enable ? 1'b1 : rx_dir_bit; // RQ8
    assign receive_pin_out = rx_port_latch;
    // Transmit pin drives while the port is enabled, fed by the transmitter not the latch
    assign transmit_pin_oe_n = port_enable ? 1'b0 : tx_dir_bit; // RQ9
    assign transmit_pin_out = port_enable ? tx_serial_data : tx_port_latch; // RQ10

    ////////////////////////////////////////////////////////////////////
    // Line synchroniser and oversampling tick
    ////////////////////////////////////////////////////////////////////

    // Two flops before the line is used; idle line is high
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_prev <= 1'b1;
        end
        else
        begin
            rx_s1 <= receive_pin_in;
            rx_s2 <= rx_s1;
            rx_prev <= rx_s2;
        end
    end

    // Tick at sixteen times the bit rate
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            tick_cnt <= {DIV_W{1'b0}};
        else if (tick || state == S_IDLE)
            tick_cnt <= baud_div; // RQ1
        else
            tick_cnt <= tick_cnt - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Data recovery state machine
    ////////////////////////////////////////////////////////////////////

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            sub <= 4'h0;
            bit_cnt <= 4'h0;
            votes <= 2'b00;
            receive_shift_register <= 9'h000;
            push <= 1'b0;
            push_word <= 11'h000;
        end
        else
        begin
            push <= 1'b0;
            if (!active)
                state <= S_IDLE; // RQ7
            else
            begin
                if (state != S_IDLE && tick)
                begin
                    sub <= (sub == `ASRX_OVS) ? 4'h0 : sub + 4'h1; // RQ1
                    if (sub == `ASRX_SMP_A || sub == `ASRX_SMP_B)
                        votes <= {votes[0], rx_s2};
                end
                case (state)
                    S_IDLE:
                    begin
                        sub <= 4'h0;
                        // Falling edge, unless an overrun blocks reception
                        if (rx_prev && !rx_s2 && !overrun) // RQ15 RQ18
                            state <= S_START;
                    end
                    S_START:
                    begin
                        if (centre)
                        begin
                            bit_cnt <= 4'h0;
                            // Start no longer low: abandon without error
                            state <= maj ? S_IDLE : S_DATA; // RQ15
                        end
                    end
                    S_DATA:
                    begin
                        if (centre)
                        begin
                            // One shift per bit of the majority value
                            receive_shift_register <= {maj, receive_shift_register[8:1]}; // RQ16
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == last_bit) // RQ2
                                state <= S_STOP;
                        end
                    end
                    S_STOP:
                    begin
                        if (centre)
                        begin
                            state <= S_IDLE;
                            push <= 1'b1; // RQ3
                            // Framing flag stored with the character
                            push_word[10] <= ~maj; // RQ13 RQ16
                            push_word[8:0] <= nine ? receive_shift_register
                                : {1'b0, receive_shift_register[8:1]}; // RQ2
                        end
                    end
                    default:
                        state <= S_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Character FIFO
    ////////////////////////////////////////////////////////////////////

    // Address mode drops characters whose ninth bit is clear
    wire addr_drop = nine & ctrl[`ASRX_CTL_ADDR] & ~push_word[8]; // RQ14
    wire accept = push & ~addr_drop & (~full | pop) & ~overrun; // RQ4
    wire lost = push & ~addr_drop & full & ~pop & ~overrun; // RQ12

    // One storage word per entry, written at the write pointer
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1)
        begin : g_entry
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                    entry[gi] <= 11'h000;
                else if (accept && wptr == gi)
                    entry[gi] <= push_word; // RQ3 RQ5
            end
        end
    endgenerate

    // Pointers, fill count and overrun state
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            overrun <= 1'b0;
            ev_oerr <= 1'b0;
        end
        else
        begin
            ev_oerr <= lost;
            if (accept)
                wptr <= wptr + 1'b1;
            if (pop)
                rptr <= rptr + 1'b1; // RQ17
            if (accept && !pop)
                count <= count + 1'b1;
            else if (pop && !accept)
                count <= count - 1'b1;
            // Cleared by switching the receiver off; a new overrun wins
            if (lost)
                overrun <= 1'b1; // RQ12 RQ18
            else if (!rx_enable)
                overrun <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers and interrupt
    ////////////////////////////////////////////////////////////////////

    assign events = {accept & push_word[10], ev_oerr, accept};
    assign irq = |(irq_st & irq_mask);

    // Writable registers; sticky events win over read-clear
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `ASRX_CTRL_RST;
            baud_div <= `ASRX_BAUD_RST;
            irq_mask <= {`ASRX_EV_W{1'b0}};
            irq_st <= {`ASRX_EV_W{1'b0}};
        end
        else
        begin
            if (wr_en && addr == `ASRX_REG_CTRL)
                ctrl <= wr_data[`ASRX_CTL_W-1:0]; // RQ7 RQ8
            if (wr_en && addr == `ASRX_REG_BAUD)
                baud_div <= wr_data[DIV_W-1:0];
            if (wr_en && addr == `ASRX_REG_MASK)
                irq_mask <= wr_data[`ASRX_EV_W-1:0];
            irq_st <= (rd_irq ? {`ASRX_EV_W{1'b0}} : irq_st) | events;
        end
    end

    // Read data, valid the cycle after the strobe
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            rd_data <= 16'h0000;
        else if (rd_en)
        begin
            case (addr)
                `ASRX_REG_CTRL: rd_data <= {{(16-`ASRX_CTL_W){1'b0}}, ctrl};
                `ASRX_REG_STAT: rd_data <= {12'h000, top[8], top[10] & ~empty,
                    overrun, rx_flag}; // RQ19 RQ12 RQ13
                `ASRX_REG_DATA: rd_data <= empty ? 16'h0000 : {7'h00, top[8:0]}; // RQ5
                `ASRX_REG_BAUD: rd_data <= baud_div;
                `ASRX_REG_IRQ: rd_data <= {13'h0000, irq_st};
                `ASRX_REG_MASK: rd_data <= {13'h0000, irq_mask};
                default: rd_data <= 16'h0000;
            endcase
        end
        else
            rd_data <= 16'h0000;
    end

endmodule

/* File: asrx_sva.sv */
/* Checker of the receiver pin overrides and register port.
   Assumes a bind onto asrx_receiver; it shadows control and mask writes. */
`timescale 1ns/1ps
`include "asrx_consts.vh"
module asrx_sva (
    input wire clk,
    input wire rst,
    input wire [3:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [15:0] rd_data,
    input wire irq,
    input wire receive_pin_oe_n,
    input wire transmit_pin_oe_n,
    input wire transmit_pin_out,
    input wire tx_serial_data
);
    reg [4:0] ctl;
    reg [2:0] msk;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // Shadow copies of control and mask, written like the registers
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctl <= 5'h00;
            msk <= 3'h0;
        end
        else if (wr_en && addr == `ASRX_REG_CTRL)
            ctl <= wr_data[4:0];
        else if (wr_en && addr == `ASRX_REG_MASK)
            msk <= wr_data[2:0];
    end
    ////////////////////////////////////////////////////////////////
    AST_TX_DRIVE: assert property (ctl[2] |-> !transmit_pin_oe_n)
        else $error("tx pin not driven");
    AST_TX_SOURCE: assert property (ctl[2] |-> transmit_pin_out == tx_serial_data)
        else $error("tx pin not from serial data");
    AST_RX_INPUT: assert property (ctl[2] |-> receive_pin_oe_n)
        else $error("rx pin driven");
    AST_CTRL_READ: assert property (rd_en && addr == `ASRX_REG_CTRL |=> rd_data == {11'h000, $past(ctl)})
        else $error("control readback wrong");
    AST_FLAG_OFF: assert property (rd_en && addr == `ASRX_REG_STAT && !ctl[0] |=> !rd_data[0])
        else $error("flag set while disabled");
    AST_IRQ_MASK: assert property (msk == 3'h0 |-> !irq)
        else $error("irq while masked");
    AST_UNMAPPED: assert property (rd_en && addr > 4'h5 |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    AST_DATA_WIDTH: assert property (rd_en && addr == `ASRX_REG_DATA |=> rd_data[15:9] == 7'h00)
        else $error("data above nine bits");
endmodule
bind asrx_receiver asrx_sva u_sva (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .receive_pin_oe_n(receive_pin_oe_n), .transmit_pin_oe_n(transmit_pin_oe_n),
    .transmit_pin_out(transmit_pin_out), .tx_serial_data(tx_serial_data));

/* File: asrx_peer.sv */
/* Remote asynchronous transmitter driving the receive line.
   Assumes the bench gives the bit time in clocks; the line idles high. */
`timescale 1ns/1ps
module asrx_peer (
    input wire clk,
    output reg line
);
    integer i;
    initial line = 1'b1;
    ////////////////////////////////////////////////////////////////
    // One frame: start, n data bits LSB first, stop good or low
    task send(input [8:0] ch, input integer n, input stop, input integer bt);
    begin
        @(posedge clk);
        line <= 1'b0;
        repeat (bt) @(posedge clk);
        for (i = 0; i < n; i = i + 1)
        begin
            line <= ch[i];
            repeat (bt) @(posedge clk);
        end
        line <= stop;
        repeat (bt) @(posedge clk);
        line <= 1'b1;
    end
    endtask
    // Short low pulse that fails the start recheck
    task glitch(input integer bt);
    begin
        @(posedge clk);
        line <= 1'b0;
        repeat (bt / 4) @(posedge clk);
        line <= 1'b1;
        repeat (bt * 2) @(posedge clk);
    end
    endtask
endmodule

/* File: tb_top.sv */
/* Self-checking bench of the serial receiver with a remote transmitter.
   Assumes a divisor of 1, so one bit lasts 32 clocks of 50 ns. */
`timescale 1ns/1ps
`include "asrx_consts.vh"
module tb_top;
    localparam BT = 32;
    localparam [3:0] CT = `ASRX_REG_CTRL, ST = `ASRX_REG_STAT, DT = `ASRX_REG_DATA;
    localparam [3:0] BD = `ASRX_REG_BAUD, IQ = `ASRX_REG_IRQ, MK = `ASRX_REG_MASK;
    localparam [15:0] F = 16'hFFFF;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] addr = 4'h0;
    reg [15:0] wr_data = 16'h0000;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg rd_q = 1'b0;
    reg [4:0] pins = 5'h00;
    reg [8:0] b [0:3];
    logic [15:0] exp_q [$];
    logic [15:0] msk_n;
    logic [15:0] exp_n;
    wire [15:0] rd_data;
    wire irq;
    wire line;
    integer errors = 0;
    integer checks = 0;
    integer cycles = 0;
    integer seed;
    integer i;
    asrx_receiver u_dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .receive_pin_in(line),
        .receive_pin_oe_n(), .receive_pin_out(), .rx_port_latch(pins[0]),
        .rx_dir_bit(pins[1]), .transmit_pin_oe_n(), .transmit_pin_out(),
        .tx_serial_data(pins[2]), .tx_port_latch(pins[3]), .tx_dir_bit(pins[4]));
    asrx_peer u_peer (.clk(clk), .line(line));
    ////////////////////////////////////////////////////////////////
    // Clock, random pin levels and the hang limit
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        pins <= 5'($urandom);
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            errors = errors + 1;
            results;
        end
    end
    // Read data compared with the oldest noted expectation
    always @(negedge clk)
    begin
        if (rd_q)
        begin
            msk_n = exp_q.pop_front();
            exp_n = exp_q.pop_front();
            check("rd_data", rd_data & msk_n, exp_n);
        end
        rd_q = rd_en;
    end
    ////////////////////////////////////////////////////////////////
    task check(input string n, input [15:0] seen, input [15:0] want);
    begin
        checks = checks + 1;
        if (seen !== want)
        begin
            errors = errors + 1;
            $display("CHECK FAILED %0s exp %h seen %h", n, want, seen);
        end
    end
    endtask
    task wr(input [3:0] a, input [15:0] d);
    begin
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    end
    endtask
    // Notes mask then expected value, then issues the read
    task rd(input [3:0] a, input [15:0] m, input [15:0] e);
    begin
        exp_q.push_back(m);
        exp_q.push_back(e & m);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
    end
    endtask
    task tx(input [8:0] c, input integer n, input s);
    begin
        u_peer.send(c, n, s, BT);
        repeat (8) @(posedge clk);
    end
    endtask
    task results;
    begin
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        seed = $urandom(1267);
        for (i = 0; i < 4; i = i + 1)
            b[i] = 9'($urandom);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wr(4'h7, F);
        wr(DT, 16'h00AA);
        rd(CT, F, 16'h0000);
        rd(BD, F, `ASRX_BAUD_RST);
        rd(4'h7, F, 16'h0000);
        rd(DT, F, 16'h0000);
        $display("reset test done");
        wr(BD, 16'h0001);
        wr(MK, 16'h0007);
        // Receive line carries digital levels only, no analog use to clear
        wr(CT, 16'h0005);
        tx(b[0], 8, 1'b1);
        rd(ST, 16'h000F, 16'h0001);
        @(negedge clk) check("irq", {15'h0000, irq}, 16'h0001);
        // A pending event stays silent while its mask bit is clear
        wr(MK, 16'h0000);
        @(negedge clk) check("irq", {15'h0000, irq}, 16'h0000);
        wr(MK, 16'h0007);
        rd(IQ, 16'h0007, 16'h0001);
        rd(DT, F, {8'h00, b[0][7:0]});
        rd(ST, 16'h0001, 16'h0000);
        @(negedge clk) check("irq", {15'h0000, irq}, 16'h0000);
        $display("single test done");
        for (i = 1; i < 4; i = i + 1)
            u_peer.send(b[i], 8, 1'b1, BT);
        tx(9'h03C, 8, 1'b1);
        rd(ST, 16'h0002, 16'h0002);
        rd(DT, F, {8'h00, b[1][7:0]});
        rd(DT, F, {8'h00, b[2][7:0]});
        rd(DT, F, 16'h0000);
        rd(IQ, 16'h0002, 16'h0002);
        wr(CT, 16'h0004);
        wr(CT, 16'h0005);
        rd(ST, 16'h0002, 16'h0000);
        $display("overrun test done");
        tx(b[0], 8, 1'b0);
        rd(ST, 16'h0005, 16'h0005);
        rd(IQ, 16'h0004, 16'h0004);
        rd(DT, F, {8'h00, b[0][7:0]});
        u_peer.glitch(BT);
        for (i = 0; i < 2; i = i + 1)
        begin
            wr(CT, i ? 16'h0004 : 16'h0007);
            tx(b[1], 8, 1'b1);
        end
        wr(CT, 16'h0005);
        rd(DT, F, 16'h0000);
        $display("framing and enable test done");
        wr(CT, 16'h000D);
        tx(b[2] | 9'h100, 9, 1'b1);
        // Flag drops while the receiver is off, the character stays
        wr(CT, 16'h000C);
        rd(ST, 16'h0001, 16'h0000);
        wr(CT, 16'h000D);
        rd(ST, 16'h0008, 16'h0008);
        rd(DT, F, {7'h00, b[2] | 9'h100});
        wr(CT, 16'h001D);
        tx(b[3] & 9'h0FF, 9, 1'b1);
        tx(b[3] | 9'h100, 9, 1'b1);
        rd(DT, F, {7'h00, b[3] | 9'h100});
        rd(DT, F, 16'h0000);
        $display("nine bit test done");
        results;
    end
endmodule
